// ---- core/sram_host_consts.svh ----
// constants for the asynchronous static memory host controller
`ifndef SRAM_HOST_CONSTS_SVH
`define SRAM_HOST_CONSTS_SVH

`define CLK_PERIOD_NS 10
`define T_AA_NS 55
`define T_PWE_NS 40
`define T_SD_NS 25
`define T_HZ_NS 18
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define REG_CTRL 8'h00
`define REG_ADDR 8'h04
`define REG_WDATA 8'h08
`define REG_RDATA 8'h0C
`define REG_STATUS 8'h10
`define REG_IRQ_STAT 8'h14
`define REG_IRQ_MASK 8'h18
`define REG_WAIT 8'h1C
`define REG_CORR_CNT 8'h20

`define CTRL_START 0
`define CTRL_WRITE 1
`define CTRL_LANE_LO 2
`define CTRL_LANE_HI 3
`define CTRL_WIDE 4
`define CTRL_AUTOINC 5

`define STAT_BUSY 0
`define STAT_LAST_ERR 1
`define RDATA_ERR 16

`define IRQ_DONE 0
`define IRQ_CORR 1
`define IRQ_REFUSED 2
`define IRQ_COUNT 3

`define WAIT_RD_LSB 0
`define WAIT_WR_LSB 4

`define RESET_LANES 2'h3
`define RESET_WIDE 1'h1

`endif

// ---- core/sram_host_pkg.sv ----
// types shared by the static memory host controller
`default_nettype none
package sram_host_pkg;
    typedef enum {
        ST_IDLE,
        ST_SETUP,
        ST_READ,
        ST_WR_PULSE,
        ST_WR_HOLD,
        ST_RECOVER
    } seq_state_type;
    typedef logic [1:0] lane_mask_type;
    typedef logic [15:0] mem_word_type;
endpackage : sram_host_pkg
`default_nettype wire

// ---- core/lane_link_if.sv ----
// link between the access sequencer and the byte lane data path
`default_nettype none
interface lane_link_if;
    import sram_host_pkg::*;
    logic wide;
    lane_mask_type lanes;
    mem_word_type wdata;
    logic drive;
    logic capture;
    mem_word_type rdata;
    modport seq (
        output wide,
        output lanes,
        output wdata,
        output drive,
        output capture,
        input rdata
    );
    modport path (
        input wide,
        input lanes,
        input wdata,
        input drive,
        input capture,
        output rdata
    );
endinterface : lane_link_if
`default_nettype wire

// ---- core/byte_lane_path.sv ----
// per-lane data drive and read capture for the memory data lines
`default_nettype none
module byte_lane_path
    import sram_host_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    lane_link_if.path link,
    input wire logic [15:0] mem_data_i,
    output logic [15:0] mem_data_o,
    output logic [15:0] mem_data_oe_o
);
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : lane
            // byte mode uses only the lower lines
            wire used = link.wide ? link.lanes[g] : (g == 0);
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    mem_data_o[g*8 +: 8] <= 8'h00;
                    mem_data_oe_o[g*8 +: 8] <= 8'h00;
                    link.rdata[g*8 +: 8] <= 8'h00;
                end else begin
                    mem_data_o[g*8 +: 8] <= link.wdata[g*8 +: 8];
                    mem_data_oe_o[g*8 +: 8] <= {8{link.drive & used}};
                    if (link.capture) begin
                        link.rdata[g*8 +: 8] <=
                            used ? mem_data_i[g*8 +: 8] : 8'h00;
                    end
                end
            end
        end
    endgenerate
endmodule : byte_lane_path
`default_nettype wire

// ---- core/irq_block.sv ----
// sticky interrupt status with mask and one level output
`default_nettype none
module irq_block #(
    parameter int N = 3
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [N-1:0] event_i,
    input wire logic stat_we_i,
    input wire logic mask_we_i,
    input wire logic [N-1:0] wdata_i,
    output logic [N-1:0] status_o,
    output logic [N-1:0] mask_o,
    output logic irq_o
);
    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : bitn
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    status_o[g] <= 1'b0;
                    mask_o[g] <= 1'b0;
                end else begin
                    // a new event wins over a write-one clear
                    if (event_i[g]) begin
                        status_o[g] <= 1'b1;
                    end else if (stat_we_i && wdata_i[g]) begin
                        status_o[g] <= 1'b0;
                    end
                    if (mask_we_i) begin
                        mask_o[g] <= wdata_i[g];
                    end
                end
            end
        end
    endgenerate
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(status_o & mask_o);
        end
    end
endmodule : irq_block
`default_nettype wire

// ---- core/sram_host_ctrl.sv ----
// wishbone-controlled host for an asynchronous static memory with ecc flag
//
// Register access over Wishbone and the register offsets were left to the implementer.
`include "sram_host_consts.svh"
`default_nettype none
module sram_host_ctrl
    import sram_host_pkg::*;
#(
    parameter int ADDR_W = 22,
    parameter int CNT_W = 5
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    output logic select_active_low_o,
    output logic select_active_high_o,
    output logic write_strobe_n_o,
    output logic output_strobe_n_o,
    output logic upper_lane_enable_n_o,
    output logic lower_lane_enable_n_o,
    output logic width_strap_o,
    output logic [ADDR_W-1:0] mem_addr_o,
    input wire logic [15:0] mem_data_i,
    output logic [15:0] mem_data_o,
    output logic [15:0] mem_data_oe_o,
    input wire logic err_flag_i
);
    localparam logic [CNT_W-1:0] AA_CYC = CNT_W'(`CYC_UP(`T_AA_NS));
    localparam logic [CNT_W-1:0] PWE_CYC = CNT_W'(`CYC_UP(`T_PWE_NS));
    localparam logic [CNT_W-1:0] SD_CYC = CNT_W'(`CYC_UP(`T_SD_NS));
    localparam logic [CNT_W-1:0] HZ_CYC = CNT_W'(`CYC_UP(`T_HZ_NS));
    localparam logic [CNT_W-1:0] WR_CYC =
        (PWE_CYC > SD_CYC) ? PWE_CYC : SD_CYC;

    seq_state_type state_reg;
    seq_state_type state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic ack_reg;
    logic [31:0] dat_reg;
    logic write_reg;
    lane_mask_type lanes_reg;
    logic wide_reg;
    logic autoinc_reg;
    logic [ADDR_W-1:0] addr_reg;
    mem_word_type wdata_reg;
    logic last_err_reg;
    logic [3:0] rd_wait_reg;
    logic [3:0] wr_wait_reg;
    logic [15:0] corr_cnt_reg;
    logic sel_n_reg;
    logic sel_reg;
    logic we_n_reg;
    logic oe_n_reg;
    logic hi_n_reg;
    logic lo_n_reg;
    logic [`IRQ_COUNT-1:0] irq_status;
    logic [`IRQ_COUNT-1:0] irq_mask;
    logic irq_line;

    lane_link_if link ();

    // bus decode
    wire wb_req = wb_cyc_i & wb_stb_i & ~ack_reg;
    wire wb_wr = wb_req & wb_we_i;
    wire [31:0] bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                         {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire wr_data_bits = |bmask;
    wire hit_ctrl = wb_adr_i == `REG_CTRL;
    wire hit_addr = wb_adr_i == `REG_ADDR;
    wire hit_wdata = wb_adr_i == `REG_WDATA;
    wire hit_rdata = wb_adr_i == `REG_RDATA;
    wire hit_status = wb_adr_i == `REG_STATUS;
    wire hit_istat = wb_adr_i == `REG_IRQ_STAT;
    wire hit_imask = wb_adr_i == `REG_IRQ_MASK;
    wire hit_wait = wb_adr_i == `REG_WAIT;
    wire hit_corr = wb_adr_i == `REG_CORR_CNT;
    wire idle = state_reg == ST_IDLE;

    // current register words
    wire [31:0] ctrl_word = {26'h0, autoinc_reg, wide_reg, lanes_reg,
                             write_reg, 1'b0};
    wire [31:0] addr_word = 32'(addr_reg);
    wire [31:0] wdata_word = {16'h0, wdata_reg};
    wire [31:0] rdata_word = {15'h0, last_err_reg, link.rdata};
    wire [31:0] status_word = {30'h0, last_err_reg, ~idle};
    wire [31:0] istat_word = 32'(irq_status);
    wire [31:0] imask_word = 32'(irq_mask);
    wire [31:0] wait_word = {24'h0, wr_wait_reg, rd_wait_reg};
    wire [31:0] corr_word = {16'h0, corr_cnt_reg};

    // byte-lane merge of write data
    wire [31:0] ctrl_m = (ctrl_word & ~bmask) | (wb_dat_i & bmask);
    wire [31:0] addr_m = (addr_word & ~bmask) | (wb_dat_i & bmask);
    wire [31:0] wdata_m = (wdata_word & ~bmask) | (wb_dat_i & bmask);
    wire [31:0] imask_m = (imask_word & ~bmask) | (wb_dat_i & bmask);
    wire [31:0] wait_m = (wait_word & ~bmask) | (wb_dat_i & bmask);

    // setup writes are locked out while an access runs
    wire ctrl_we = wb_wr & hit_ctrl & idle;
    wire addr_we = wb_wr & hit_addr & idle;
    wire wdata_we = wb_wr & hit_wdata & idle;
    wire wait_we = wb_wr & hit_wait & idle;
    wire corr_we = wb_wr & hit_corr & wr_data_bits;
    wire start_req = wb_wr & hit_ctrl & bmask[`CTRL_START]
                     & wb_dat_i[`CTRL_START];
    wire [1:0] lanes_m = {ctrl_m[`CTRL_LANE_HI], ctrl_m[`CTRL_LANE_LO]};
    // wide mode with no lane would only be standby: refuse it
    wire no_lane = ctrl_m[`CTRL_WIDE] & (lanes_m == 2'b00);
    wire launch = start_req & idle & ~no_lane;
    wire refused = start_req & (~idle | no_lane);

    wire [31:0] rd_word =
        hit_ctrl ? ctrl_word :
        hit_addr ? addr_word :
        hit_wdata ? wdata_word :
        hit_rdata ? rdata_word :
        hit_status ? status_word :
        hit_istat ? istat_word :
        hit_imask ? imask_word :
        hit_wait ? wait_word :
        hit_corr ? corr_word : 32'h0;

    // access sequencer
    wire [CNT_W-1:0] rd_len = AA_CYC + CNT_W'(rd_wait_reg);
    wire [CNT_W-1:0] wr_len = WR_CYC + CNT_W'(wr_wait_reg);
    wire cnt_last = cnt_reg == CNT_W'(1);
    // error flag sampled on the same edge as read data
    wire capture = (state_reg == ST_READ) & cnt_last;
    wire done_evt = (state_reg == ST_RECOVER) & cnt_last;
    // flag only means something while a read drives outputs
    wire corr_evt = capture & err_flag_i;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            ST_IDLE: begin
                if (launch) begin
                    state_next = ST_SETUP;
                end
            end
            ST_SETUP: begin
                // address settles one cycle before select
                if (write_reg) begin
                    state_next = ST_WR_PULSE;
                    cnt_next = wr_len;
                end else begin
                    state_next = ST_READ;
                    cnt_next = rd_len;
                end
            end
            ST_READ: begin
                if (cnt_last) begin
                    state_next = ST_RECOVER;
                    cnt_next = HZ_CYC;
                end else begin
                    cnt_next = cnt_reg - CNT_W'(1);
                end
            end
            ST_WR_PULSE: begin
                if (cnt_last) begin
                    state_next = ST_WR_HOLD;
                end else begin
                    cnt_next = cnt_reg - CNT_W'(1);
                end
            end
            ST_WR_HOLD: begin
                state_next = ST_RECOVER;
                cnt_next = HZ_CYC;
            end
            ST_RECOVER: begin
                // memory outputs reach high impedance before next drive
                if (cnt_last) begin
                    state_next = ST_IDLE;
                end else begin
                    cnt_next = cnt_reg - CNT_W'(1);
                end
            end
            default: begin
                state_next = ST_IDLE;
                cnt_next = '0;
            end
        endcase
    end

    wire sel_next = (state_next == ST_READ) | (state_next == ST_WR_PULSE)
                    | (state_next == ST_WR_HOLD);
    wire we_next = state_next == ST_WR_PULSE;
    wire oe_next = state_next == ST_READ;
    wire drive_next = (state_next == ST_WR_PULSE)
                      | (state_next == ST_WR_HOLD);
    // byte mode leaves lane enables low, the memory ignores them
    wire [1:0] lane_on = wide_reg ? lanes_reg : 2'b11;

    assign link.wide = wide_reg;
    assign link.lanes = lanes_reg;
    assign link.wdata = wdata_reg;
    assign link.drive = drive_next;
    assign link.capture = capture;

    byte_lane_path u_path (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .link(link.path),
        .mem_data_i(mem_data_i),
        .mem_data_o(mem_data_o),
        .mem_data_oe_o(mem_data_oe_o)
    );

    irq_block #(
        .N(`IRQ_COUNT)
    ) u_irq (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .event_i({refused, corr_evt, done_evt}),
        .stat_we_i(wb_wr & hit_istat),
        .mask_we_i(wb_wr & hit_imask),
        .wdata_i(hit_istat ? (wb_dat_i[`IRQ_COUNT-1:0]
                              & bmask[`IRQ_COUNT-1:0])
                           : imask_m[`IRQ_COUNT-1:0]),
        .status_o(irq_status),
        .mask_o(irq_mask),
        .irq_o(irq_line)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
            cnt_reg <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    // bus slave, ack one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0;
        end else begin
            ack_reg <= wb_req;
            if (wb_req) begin
                dat_reg <= rd_word;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            write_reg <= 1'b0;
            lanes_reg <= `RESET_LANES;
            wide_reg <= `RESET_WIDE;
            autoinc_reg <= 1'b0;
            rd_wait_reg <= 4'h0;
            wr_wait_reg <= 4'h0;
            wdata_reg <= 16'h0;
        end else begin
            if (ctrl_we) begin
                write_reg <= ctrl_m[`CTRL_WRITE];
                lanes_reg <= lanes_m;
                wide_reg <= ctrl_m[`CTRL_WIDE];
                autoinc_reg <= ctrl_m[`CTRL_AUTOINC];
            end
            if (wait_we) begin
                rd_wait_reg <= wait_m[`WAIT_RD_LSB +: 4];
                wr_wait_reg <= wait_m[`WAIT_WR_LSB +: 4];
            end
            if (wdata_we) begin
                wdata_reg <= wdata_m[15:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            addr_reg <= '0;
        end else if (addr_we) begin
            addr_reg <= addr_m[ADDR_W-1:0];
        end else if (done_evt && autoinc_reg) begin
            addr_reg <= addr_reg + ADDR_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_err_reg <= 1'b0;
            corr_cnt_reg <= 16'h0;
        end else begin
            if (capture) begin
                last_err_reg <= err_flag_i;
            end
            if (corr_evt && corr_cnt_reg != 16'hFFFF) begin
                corr_cnt_reg <= corr_cnt_reg + 16'h0001;
            end else if (corr_we) begin
                corr_cnt_reg <= 16'h0;
            end
        end
    end

    // pin flops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel_n_reg <= 1'b1;
            sel_reg <= 1'b0;
            we_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            hi_n_reg <= 1'b1;
            lo_n_reg <= 1'b1;
        end else begin
            sel_n_reg <= ~sel_next;
            sel_reg <= sel_next;
            // strobe rises first and ends the write, data still held
            we_n_reg <= ~we_next;
            oe_n_reg <= ~oe_next;
            hi_n_reg <= ~(sel_next & lane_on[1]);
            lo_n_reg <= ~(sel_next & lane_on[0]);
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign irq_o = irq_line;
    assign select_active_low_o = sel_n_reg;
    assign select_active_high_o = sel_reg;
    assign write_strobe_n_o = we_n_reg;
    assign output_strobe_n_o = oe_n_reg;
    assign upper_lane_enable_n_o = hi_n_reg;
    assign lower_lane_enable_n_o = lo_n_reg;
    assign width_strap_o = wide_reg;
    assign mem_addr_o = addr_reg;
endmodule : sram_host_ctrl
`default_nettype wire

// ---- sim/sram_host_properties.sv ----
// pin-level checks for the static memory host controller
`default_nettype none
module sram_host_properties #(
    parameter int ADDR_W = 22
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic select_active_low_o,
    input wire logic select_active_high_o,
    input wire logic write_strobe_n_o,
    input wire logic output_strobe_n_o,
    input wire logic upper_lane_enable_n_o,
    input wire logic lower_lane_enable_n_o,
    input wire logic width_strap_o,
    input wire logic [ADDR_W-1:0] mem_addr_o,
    input wire logic [15:0] mem_data_o,
    input wire logic [15:0] mem_data_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic sel = !select_active_low_o && select_active_high_o;
    wire logic [15:0] lane_oe = {{8{!upper_lane_enable_n_o && width_strap_o}},
        {8{!lower_lane_enable_n_o}}};
    sequence wr_low;
        !write_strobe_n_o [*4];
    endsequence
    sequence rd_hold;
        (!output_strobe_n_o && sel) [*6];
    endsequence
    sequence wr_end;
        sel && $stable(mem_data_o) && mem_data_oe_o != 16'h0
        ##1 !sel && mem_data_oe_o == 16'h0;
    endsequence
    sel_pair_a: assert property (
        select_active_low_o == !select_active_high_o)
        else $error("selects out of step");
    rd_we_high_a: assert property (
        !output_strobe_n_o |-> write_strobe_n_o)
        else $error("write strobe low in read");
    no_contend_a: assert property (
        !output_strobe_n_o |-> mem_data_oe_o == 16'h0)
        else $error("host drives data during read");
    addr_stable_a: assert property (
        sel |-> $stable(mem_addr_o))
        else $error("address moved while selected");
    we_qualified_a: assert property (
        !write_strobe_n_o |-> sel && !(upper_lane_enable_n_o
        && lower_lane_enable_n_o))
        else $error("write strobe without qualifiers");
    wr_min_a: assert property (
        $fell(write_strobe_n_o) |-> wr_low)
        else $error("write pulse too short");
    wr_end_a: assert property (
        $rose(write_strobe_n_o) |-> wr_end)
        else $error("write end not strobe controlled");
    rd_len_a: assert property (
        $fell(output_strobe_n_o) |-> rd_hold)
        else $error("read access too short");
    lane_data_a: assert property (
        !write_strobe_n_o |-> mem_data_oe_o == lane_oe)
        else $error("driven lanes differ from enables");
    standby_a: assert property (
        sel && width_strap_o |-> !(upper_lane_enable_n_o
        && lower_lane_enable_n_o))
        else $error("selected with no lane in wide mode");
endmodule : sram_host_properties
bind sram_host_ctrl sram_host_properties #(.ADDR_W(ADDR_W)) i_props (
    .clk_i(clk_i), .rst_i(rst_i),
    .select_active_low_o(select_active_low_o),
    .select_active_high_o(select_active_high_o),
    .write_strobe_n_o(write_strobe_n_o),
    .output_strobe_n_o(output_strobe_n_o),
    .upper_lane_enable_n_o(upper_lane_enable_n_o),
    .lower_lane_enable_n_o(lower_lane_enable_n_o),
    .width_strap_o(width_strap_o), .mem_addr_o(mem_addr_o),
    .mem_data_o(mem_data_o), .mem_data_oe_o(mem_data_oe_o));
`default_nettype wire

// ---- sim/sram_model.sv ----
// behavioural static memory with corrected-error flag
`default_nettype none
module sram_model #(
    parameter int RD_DLY = 50
) (
    input wire logic select_active_low_i,
    input wire logic select_active_high_i,
    input wire logic write_strobe_n_i,
    input wire logic output_strobe_n_i,
    input wire logic upper_lane_enable_n_i,
    input wire logic lower_lane_enable_n_i,
    input wire logic width_strap_i,
    input wire logic [21:0] addr_i,
    input wire logic [15:0] dq_i,
    input wire logic [7:0] err_addr_i,
    output logic [15:0] dq_o,
    output logic err_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:511];
    logic [15:0] wd;
    logic [1:0] wl;
    wire sel = !select_active_low_i && select_active_high_i;
    wire ln_lo = !width_strap_i || !lower_lane_enable_n_i;
    wire ln_hi = width_strap_i && !upper_lane_enable_n_i;
    wire rd = sel && write_strobe_n_i && !output_strobe_n_i;
    wire wr = sel && !write_strobe_n_i && (ln_lo || ln_hi);
    wire [8:0] ix = {addr_i[7:0], 1'b0};
    wire [15:0] word = {mem[ix + 9'h1], mem[ix]};
    wire hit = addr_i[7:0] == err_addr_i;
    wire [15:0] drv = {{8{rd && ln_hi}}, {8{rd && ln_lo}}};
    // floating lines show the inverse pattern
    assign #(RD_DLY) dq_o = word ^ ~drv;
    assign #(RD_DLY) err_o = rd ? hit : !hit;
    always @* begin
        if (wr) begin
            wd = dq_i;
            wl = {ln_hi, ln_lo};
        end
    end
    always @(negedge wr) begin
        if (wl[0]) mem[ix] = wd[7:0];
        if (wl[1]) mem[ix + 9'h1] = wd[15:8];
    end
endmodule : sram_model
`default_nettype wire

// ---- sim/testbench.sv ----
// self-checking bench for the static memory host controller
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] adr = 8'h00;
    logic [31:0] dw = 32'h0;
    logic [3:0] sel = 4'h0;
    logic we = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic [7:0] err_addr = 8'hFF;
    logic [31:0] rd, dr;
    logic ack, irq, cs_n, cs, we_n, oe_n, ub_n, lb_n, strap, m_err;
    logic [21:0] maddr;
    logic [15:0] h_dq, h_oe, m_dq;
    wire logic [15:0] dq = (h_dq & h_oe) | (m_dq & ~h_oe);
    int n_errors = 0;
    int comparisons = 0;
    always #5 clk_i = ~clk_i;
    sram_host_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
        .wb_dat_i(dw), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_dat_o(rd), .wb_ack_o(ack), .irq_o(irq),
        .select_active_low_o(cs_n), .select_active_high_o(cs),
        .write_strobe_n_o(we_n), .output_strobe_n_o(oe_n),
        .upper_lane_enable_n_o(ub_n), .lower_lane_enable_n_o(lb_n),
        .width_strap_o(strap), .mem_addr_o(maddr), .mem_data_i(dq),
        .mem_data_o(h_dq), .mem_data_oe_o(h_oe), .err_flag_i(m_err));
    sram_model i_mem (.select_active_low_i(cs_n),
        .select_active_high_i(cs), .write_strobe_n_i(we_n),
        .output_strobe_n_i(oe_n), .upper_lane_enable_n_i(ub_n),
        .lower_lane_enable_n_i(lb_n), .width_strap_i(strap),
        .addr_i(maddr), .dq_i(dq), .err_addr_i(err_addr), .dq_o(m_dq),
        .err_o(m_err));
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report
    task automatic give_up;
        n_errors++;
        final_report();
    endtask : give_up
    task automatic check(input string what, input logic [31:0] exp,
            input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic wb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dw <= d;
        sel <= 4'hF;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 40);
        if (n >= 40) give_up();
        dr = rd;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb
    task automatic op(input logic [7:0] ctl, input logic [21:0] a,
            input logic [15:0] d);
        int n;
        wb(1'b1, 8'h04, {10'h0, a});
        wb(1'b1, 8'h08, {16'h0, d});
        wb(1'b1, 8'h00, {24'h0, ctl});
        n = 0;
        do begin
            wb(1'b0, 8'h10, 32'h0);
            n++;
        end while (dr[0] !== 1'b0 && n < 40);
        if (n >= 40) give_up();
    endtask : op
    task automatic read_back(input logic [7:0] ctl, input logic [21:0] a,
            input logic [31:0] exp);
        op(ctl, a, 16'h0);
        wb(1'b0, 8'h0C, 32'h0);
        check("read data", exp, dr);
    endtask : read_back
    task automatic t_reset;
        check("idle pins", 32'h6F, {25'h0, strap, cs_n, cs, we_n, oe_n,
            ub_n, lb_n});
        wb(1'b0, 8'h00, 32'h0);
        check("control", 32'h1C, dr);
        wb(1'b0, 8'h18, 32'h0);
        check("irq mask", 32'h0, dr);
        wb(1'b0, 8'h3C, 32'h0);
        check("unmapped", 32'h0, dr);
        $display("reset test done");
    endtask : t_reset
    task automatic t_lanes;
        op(8'h1F, 22'h5, 16'hA5C3);
        read_back(8'h1D, 22'h5, 32'hA5C3);
        op(8'h17, 22'h5, 16'h1234);
        op(8'h1B, 22'h5, 16'h7800);
        read_back(8'h1D, 22'h5, 32'h7834);
        read_back(8'h15, 22'h5, 32'h0034);
        read_back(8'h19, 22'h5, 32'h7800);
        $display("lane test done");
    endtask : t_lanes
    task automatic t_byte;
        op(8'h03, 22'h7, 16'hFF5A);
        read_back(8'h01, 22'h7, 32'h005A);
        read_back(8'h15, 22'h7, 32'h005A);
        $display("byte test done");
    endtask : t_byte
    task automatic t_err;
        wb(1'b1, 8'h14, 32'h7);
        wb(1'b1, 8'h18, 32'h2);
        err_addr <= 8'h05;
        read_back(8'h1D, 22'h5, 32'h17834);
        wb(1'b0, 8'h10, 32'h0);
        check("status", 32'h2, dr);
        repeat (2) @(posedge clk_i);
        check("irq raised", 32'h1, {31'h0, irq});
        wb(1'b1, 8'h18, 32'h0);
        repeat (2) @(posedge clk_i);
        check("irq masked", 32'h0, {31'h0, irq});
        wb(1'b1, 8'h18, 32'h2);
        wb(1'b1, 8'h14, 32'h2);
        repeat (2) @(posedge clk_i);
        check("irq cleared", 32'h0, {31'h0, irq});
        err_addr <= 8'hFF;
        read_back(8'h1D, 22'h5, 32'h7834);
        check("irq quiet", 32'h0, {31'h0, irq});
        $display("error flag test done");
    endtask : t_err
    task automatic t_refuse;
        wb(1'b1, 8'h14, 32'h7);
        op(8'h11, 22'h5, 16'h0);
        wb(1'b0, 8'h14, 32'h0);
        check("refused", 32'h4, dr);
        $display("standby test done");
    endtask : t_refuse
    task automatic t_extras;
        wb(1'b0, 8'h20, 32'h0);
        check("error count", 32'h1, dr);
        wb(1'b1, 8'h20, 32'h0);
        wb(1'b0, 8'h20, 32'h0);
        check("count cleared", 32'h0, dr);
        wb(1'b1, 8'h1C, 32'h21);
        wb(1'b0, 8'h1C, 32'h0);
        check("wait setting", 32'h21, dr);
        // stretched write with address step at the end
        op(8'h3F, 22'h9, 16'hBEEF);
        wb(1'b0, 8'h04, 32'h0);
        check("address step", 32'hA, dr);
        read_back(8'h1D, 22'h9, 32'hBEEF);
        wb(1'b1, 8'h14, 32'h7);
        // second start lands while the first read runs
        wb(1'b1, 8'h00, 32'h1D);
        wb(1'b1, 8'h00, 32'h1D);
        wb(1'b0, 8'h14, 32'h0);
        check("busy refusal", 32'h4, dr);
        repeat (20) @(posedge clk_i);
        $display("extras test done");
    endtask : t_extras
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_lanes();
        t_byte();
        t_err();
        t_extras();
        t_refuse();
        final_report();
    end
endmodule : testbench
`default_nettype wire
